//--- design/gsm_shutdown_monitor.sv
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`include "gsm_cfg.svh"
module gsm_shutdown_monitor #(
    parameter int NSETP = 8, // setpoints held
    parameter int SP_W = 16, // setpoint width
    parameter int HDEPTH = 33, // history entries
    parameter int CHK_CYCLES = `GSM_CHK_CYCLES // cycles between checks
) (
    input wire logic ref_clk, // 20 MHz clock
    input wire logic rst_b, // sync reset, low
    input wire logic clkEn, // freezes state when low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write access
    input wire logic [2:0] hsize, // word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire logic [`GSM_PR_W-1:0] pressure, // measured pressure code
    input wire logic emisHigh, // high emission range
    input gsm_pkg::gsm_keys_t keys, // key pulses
    input gsm_pkg::gsm_off_t offSrc, // commanded off pulses
    input gsm_pkg::gsm_psu_t psuFault, // supply fault levels
    output logic [$clog2(NSETP)-1:0] nvmIdx, // storage read index
    input wire logic [SP_W-1:0] nvmData, // storage data, next cycle
    output logic ionGaugeOn, // gauge enable
    output logic faultRelay, // relay energised when high
    output logic [$clog2(HDEPTH+1)-1:0] dispIdx, // shown entry index
    output gsm_pkg::gsm_evt_t dispEvt, // shown entry
    output logic irq // interrupt level
);

    localparam int SIW = $clog2(NSETP);
    localparam int HIW = $clog2(HDEPTH + 1);
    localparam int TW = $clog2(CHK_CYCLES + 1);

    // refuse sizes the logic cannot serve
    generate
        if (NSETP < 2 || (1 << SIW) != NSETP || SP_W < 16 || SP_W > 32 ||
            HDEPTH < 2 || HDEPTH > 63 || CHK_CYCLES < NSETP + 2)
        begin : gBadParam
            $error("gsm_shutdown_monitor: unsupported parameter values");
        end
    endgenerate

    logic addrAcc; // address phase taken
    logic wrPend_r; // write data phase
    logic [7:0] wrAddr_r; // latched write offset
    logic [31:0] rdVal; // read mux
    logic rdStat; // status read, clears
    logic [1:0] menu_r; // menu mode
    logic [`GSM_ST_W-1:0] stat_r; // sticky events
    logic [`GSM_ST_W-1:0] statNxt; // next sticky value
    logic [`GSM_ST_W-1:0] evSet; // events this cycle
    logic [`GSM_ST_W-1:0] mask_r; // interrupt mask
    logic [SIW-1:0] spSel_r; // setpoint window
    logic [SP_W-1:0] spMem_r [NSETP]; // working setpoints
    logic [SP_W-1:0] sumStored_r; // reference checksum
    logic [SP_W-1:0] sumDelta; // change to reference
    gsm_pkg::gsm_ld_t ldState_r; // power-up phase
    logic ldPhase_r; // storage read wait
    logic walkOn_r; // pass running
    logic dirty_r; // setpoint changed in pass
    logic dirtyNow; // including this cycle
    logic [TW-1:0] chkCnt_r; // cycles to next check
    logic walkGo; // launch a pass
    logic [SIW-1:0] walkIdx; // pass index
    logic badHit; // garbled setpoint seen
    logic walkDone; // pass finished
    logic [SP_W-1:0] walkSum; // pass result
    logic sumFaultSet; // mismatch this cycle
    logic swSp; // software setpoint write
    logic fzEn; // force garbled setpoint to zero
    logic onReq; // software turn-on
    logic hostOff; // software turn-off
    logic [1:0] pctSel_r; // retained percent choice
    logic [1:0] pctEdit_r; // percent being edited
    logic editing_r; // percent flashing
    logic [`GSM_PR_W-1:0] ovpLimit; // active threshold
    logic overPr; // above threshold
    logic pushEn; // log an event
    gsm_pkg::gsm_evt_t pushEvt; // event to log
    logic [HIW-1:0] viewIdx_r; // browsed entry
    gsm_pkg::gsm_evt_t histEvt; // entry at viewIdx_r
    logic [HIW-1:0] histCount; // entries logged

    assign addrAcc = hsel && htrans[1] && hready;
    assign rdStat = addrAcc && !hwrite && (haddr[7:0] == `GSM_REG_STAT);
    assign swSp = wrPend_r && (wrAddr_r == `GSM_REG_SPDAT);
    assign onReq = wrPend_r && (wrAddr_r == `GSM_REG_CTRL) && hwdata[`GSM_CTRL_ON];
    assign hostOff = wrPend_r && (wrAddr_r == `GSM_REG_CTRL) && hwdata[`GSM_CTRL_OFF];
    assign fzEn = badHit && !(swSp && (spSel_r == walkIdx));
    assign dirtyNow = dirty_r || swSp || fzEn;
    assign walkGo = !walkOn_r && ((ldState_r == gsm_pkg::LD_SUM) ||
                    ((ldState_r == gsm_pkg::LD_RUN) && (chkCnt_r == '0)));
    assign sumFaultSet = walkDone && (ldState_r == gsm_pkg::LD_RUN) && !dirtyNow &&
                         (walkSum != sumStored_r);
    assign overPr = pressure > ovpLimit;

    always_comb
    begin
        case ({emisHigh, pctSel_r})
            3'h0: ovpLimit = `GSM_OVP_L100;
            3'h1: ovpLimit = `GSM_OVP_L50;
            3'h2: ovpLimit = `GSM_OVP_L20;
            3'h3: ovpLimit = `GSM_OVP_L10;
            3'h4: ovpLimit = `GSM_OVP_H100;
            3'h5: ovpLimit = `GSM_OVP_H50;
            3'h6: ovpLimit = `GSM_OVP_H20;
            default: ovpLimit = `GSM_OVP_H10;
        endcase
    end

    // turnoff causes, supply first, then threshold, then command
    always_comb
    begin
        evSet = '0;
        pushEn = 1'b0;
        pushEvt = gsm_pkg::EV_NONE;
        if (ionGaugeOn)
        begin
            if (|psuFault)
            begin
                pushEn = 1'b1;
                pushEvt = gsm_pkg::EV_SUPPLY_OFF;
                evSet[`GSM_ST_PSU] = 1'b1;
            end
            else if (overPr)
            begin
                pushEn = 1'b1;
                pushEvt = gsm_pkg::EV_OVP_THLD;
                evSet[`GSM_ST_OVP] = 1'b1;
            end
            else if ((|offSrc) || hostOff)
            begin
                pushEn = 1'b1;
                pushEvt = gsm_pkg::EV_COMMANDED_OFF;
                evSet[`GSM_ST_CMD] = 1'b1;
            end
        end
        evSet[`GSM_ST_SUM] = sumFaultSet;
        evSet[`GSM_ST_BAD] = badHit;
    end

    // read-clear loses to a new event
    assign statNxt = evSet | (rdStat ? '0 : stat_r);

    // checksum reference moves with every setpoint write
    always_comb
    begin
        sumDelta = '0;
        if (swSp)
            sumDelta = hwdata[SP_W-1:0] - spMem_r[spSel_r];
        if (fzEn)
            sumDelta = sumDelta - spMem_r[walkIdx];
    end

    // read mux, address phase
    always_comb
    begin
        rdVal = '0;
        case (haddr[7:0])
            `GSM_REG_CTRL: rdVal[`GSM_CTRL_MENU +: 2] = menu_r;
            `GSM_REG_STAT: rdVal[`GSM_ST_W-1:0] = stat_r;
            `GSM_REG_MASK: rdVal[`GSM_ST_W-1:0] = mask_r;
            `GSM_REG_STATE:
            begin
                rdVal[`GSM_SS_ON] = ionGaugeOn;
                rdVal[`GSM_SS_RELAY] = faultRelay;
                rdVal[`GSM_SS_PCT +: 2] = pctSel_r;
                rdVal[`GSM_SS_EDIT] = editing_r;
                rdVal[`GSM_SS_CNT +: HIW] = histCount;
                rdVal[`GSM_SS_VIEW +: HIW] = viewIdx_r;
            end
            `GSM_REG_SPIDX: rdVal[SIW-1:0] = spSel_r;
            `GSM_REG_SPDAT: rdVal[SP_W-1:0] = spMem_r[spSel_r];
            `GSM_REG_OVP: rdVal[`GSM_PR_W-1:0] = ovpLimit;
            `GSM_REG_HIST: rdVal[2:0] = histEvt;
            default: rdVal = '0;
        endcase
    end

    // bus slave, zero wait, always okay
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= '0;
            wrPend_r <= 1'b0;
            wrAddr_r <= '0;
        end
        else if (clkEn)
        begin
            wrPend_r <= addrAcc && hwrite;
            wrAddr_r <= haddr[7:0];
            if (addrAcc && !hwrite)
                hrdata <= rdVal;
        end
    end

    // control, mask and window registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            menu_r <= '0;
            mask_r <= `GSM_MASK_RST;
            spSel_r <= '0;
        end
        else if (clkEn && wrPend_r)
        begin
            case (wrAddr_r)
                `GSM_REG_CTRL: menu_r <= hwdata[`GSM_CTRL_MENU +: 2];
                `GSM_REG_MASK: mask_r <= hwdata[`GSM_ST_W-1:0];
                `GSM_REG_SPIDX: spSel_r <= hwdata[SIW-1:0];
                default: ;
            endcase
        end
    end

    // sticky status and interrupt level
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            stat_r <= '0;
            irq <= 1'b0;
        end
        else if (clkEn)
        begin
            stat_r <= statNxt;
            irq <= |(statNxt & mask_r);
        end
    end

    // working setpoint store
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < NSETP; i++)
                spMem_r[i] <= '0;
        end
        else if (clkEn)
        begin
            if (ldState_r == gsm_pkg::LD_READ && ldPhase_r)
                spMem_r[nvmIdx] <= nvmData;
            if (fzEn)
                spMem_r[walkIdx] <= '0;
            if (swSp)
                spMem_r[spSel_r] <= hwdata[SP_W-1:0];
        end
    end

    // power-up load, reference checksum and periodic check
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            ldState_r <= gsm_pkg::LD_READ;
            ldPhase_r <= 1'b0;
            nvmIdx <= '0;
            walkOn_r <= 1'b0;
            dirty_r <= 1'b0;
            chkCnt_r <= '0;
            sumStored_r <= '0;
        end
        else if (clkEn)
        begin
            if (walkGo)
                chkCnt_r <= TW'(CHK_CYCLES - 1);
            else if (chkCnt_r != '0)
                chkCnt_r <= chkCnt_r - TW'(1);
            if (walkGo)
            begin
                walkOn_r <= 1'b1;
                dirty_r <= 1'b0;
            end
            else if (walkDone)
                walkOn_r <= 1'b0;
            else if (swSp || fzEn)
                dirty_r <= 1'b1;
            sumStored_r <= sumStored_r + sumDelta;
            case (ldState_r)
                gsm_pkg::LD_READ:
                begin
                    ldPhase_r <= !ldPhase_r;
                    if (ldPhase_r)
                    begin
                        if (nvmIdx == SIW'(NSETP - 1))
                            ldState_r <= gsm_pkg::LD_SUM;
                        else
                            nvmIdx <= nvmIdx + SIW'(1);
                    end
                end
                gsm_pkg::LD_SUM:
                begin
                    // first reference from a full pass
                    if (walkDone && !dirtyNow)
                    begin
                        sumStored_r <= walkSum;
                        ldState_r <= gsm_pkg::LD_RUN;
                    end
                end
                gsm_pkg::LD_RUN: ;
                default: ldState_r <= gsm_pkg::LD_READ;
            endcase
        end
    end

    // fault relay, energised from reset
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            faultRelay <= 1'b1;
        else if (clkEn && (sumFaultSet || badHit))
            faultRelay <= 1'b0;
    end

    // gauge enable
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            ionGaugeOn <= 1'b0;
        else if (clkEn)
        begin
            if (pushEn)
                ionGaugeOn <= 1'b0;
            else if (onReq)
                ionGaugeOn <= 1'b1;
        end
    end

    // front panel keys: threshold edit and history browse
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            pctSel_r <= `GSM_PCT_RST;
            pctEdit_r <= `GSM_PCT_RST;
            editing_r <= 1'b0;
            viewIdx_r <= '0;
        end
        else if (clkEn)
        begin
            case (gsm_pkg::gsm_menu_t'(menu_r))
                gsm_pkg::MENU_THLD:
                begin
                    if (!editing_r)
                    begin
                        if (keys.sel)
                        begin
                            editing_r <= 1'b1;
                            pctEdit_r <= pctSel_r;
                        end
                    end
                    else if (keys.cancel)
                        editing_r <= 1'b0;
                    else if (keys.sel)
                    begin
                        pctSel_r <= pctEdit_r;
                        editing_r <= 1'b0;
                    end
                    else if (keys.up && pctEdit_r != `GSM_PCT_RST)
                        pctEdit_r <= pctEdit_r - 2'h1;
                    else if (keys.down && pctEdit_r != `GSM_PCT_LAST)
                        pctEdit_r <= pctEdit_r + 2'h1;
                end
                gsm_pkg::MENU_HIST:
                begin
                    editing_r <= 1'b0;
                    if (keys.up && viewIdx_r != '0)
                        viewIdx_r <= viewIdx_r - HIW'(1);
                    else if (keys.down && (viewIdx_r + HIW'(1)) < histCount)
                        viewIdx_r <= viewIdx_r + HIW'(1);
                end
                default: editing_r <= 1'b0;
            endcase
        end
    end

    // display of browsed entry
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            dispIdx <= '0;
            dispEvt <= gsm_pkg::EV_NONE;
        end
        else if (clkEn)
        begin
            dispIdx <= viewIdx_r;
            dispEvt <= histEvt;
        end
    end

    gsm_hist_buf #(
        .DEPTH(HDEPTH),
        .IW(HIW)
    ) uHist (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .push(pushEn),
        .pushEvt(pushEvt),
        .rdIdx(viewIdx_r),
        .rdEvt(histEvt),
        .count(histCount)
    );

    gsm_cksum_walk #(
        .N(NSETP),
        .W(SP_W),
        .IW(SIW),
        .MAX(`GSM_SP_MAX)
    ) uWalk (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .start(walkGo),
        .idx(walkIdx),
        .spData(spMem_r[walkIdx]),
        .badHit(badHit),
        .done(walkDone),
        .sum(walkSum)
    );

endmodule // gsm_shutdown_monitor

//--- design/gsm_cfg.svh
`ifndef GSM_CFG_SVH
`define GSM_CFG_SVH

// register byte offsets on the bus
`define GSM_REG_CTRL 8'h00
`define GSM_REG_STAT 8'h04
`define GSM_REG_MASK 8'h08
`define GSM_REG_STATE 8'h0C
`define GSM_REG_SPIDX 8'h10
`define GSM_REG_SPDAT 8'h14
`define GSM_REG_OVP 8'h18
`define GSM_REG_HIST 8'h1C

// control register fields
`define GSM_CTRL_ON 0
`define GSM_CTRL_OFF 1
`define GSM_CTRL_MENU 2

// status and mask bits
`define GSM_ST_CMD 0
`define GSM_ST_PSU 1
`define GSM_ST_OVP 2
`define GSM_ST_SUM 3
`define GSM_ST_BAD 4
`define GSM_ST_W 5

// state register fields
`define GSM_SS_ON 0
`define GSM_SS_RELAY 1
`define GSM_SS_PCT 2
`define GSM_SS_EDIT 4
`define GSM_SS_CNT 8
`define GSM_SS_VIEW 16

// reset values and last percent choice
`define GSM_PCT_RST 2'h0
`define GSM_PCT_LAST 2'h3
`define GSM_MASK_RST 5'h00

// overpressure limits, pressure code in 1e-6 Torr
`define GSM_PR_W 16
`define GSM_OVP_H100 16'h4E20
`define GSM_OVP_H50 16'h2710
`define GSM_OVP_H20 16'h0FA0
`define GSM_OVP_H10 16'h07D0
`define GSM_OVP_L100 16'h0320
`define GSM_OVP_L50 16'h0190
`define GSM_OVP_L20 16'h00A0
`define GSM_OVP_L10 16'h0050

// largest setpoint code that is still meaningful
`define GSM_SP_MAX 16'hEA60

// periodic checksum interval
`define GSM_CLK_MHZ 20
`define GSM_CHK_PERIOD_US 1000
`define GSM_CHK_CYCLES (`GSM_CHK_PERIOD_US * `GSM_CLK_MHZ)

`endif

//--- design/gsm_pkg.sv
package gsm_pkg;

    // logged events: power-on and turnoff causes
    typedef enum logic [2:0] {
        EV_NONE,
        EV_PWR_ON,
        EV_COMMANDED_OFF,
        EV_SUPPLY_OFF,
        EV_OVP_THLD
    } gsm_evt_t;

    // front panel menu in use
    typedef enum logic [1:0] {MENU_NONE, MENU_THLD, MENU_HIST} gsm_menu_t;

    // power-up sequence
    typedef enum logic [1:0] {LD_READ, LD_SUM, LD_RUN} gsm_ld_t;

    // key pulses
    typedef struct packed {
        logic up;
        logic down;
        logic sel;
        logic cancel;
    } gsm_keys_t;

    // commanded turnoff sources
    typedef struct packed {
        logic panel;
        logic host;
        logic companion;
        logic remote;
    } gsm_off_t;

    // filament supply faults
    typedef struct packed {
        logic filOverCur;
        logic gridVolt;
    } gsm_psu_t;

endpackage

//--- design/gsm_hist_buf.sv
`timescale 1ns/1ps

module gsm_hist_buf #(
    parameter int DEPTH = 33, // entries kept
    parameter int IW = 6 // index width
) (
    input wire logic ref_clk, // clock
    input wire logic rst_b, // sync reset, low
    input wire logic clkEn, // freezes state when low
    input wire logic push, // insert new event
    input gsm_pkg::gsm_evt_t pushEvt, // event to insert
    input wire logic [IW-1:0] rdIdx, // entry to show
    output gsm_pkg::gsm_evt_t rdEvt, // entry at rdIdx
    output logic [IW-1:0] count // entries in use
);

    gsm_pkg::gsm_evt_t entry_r [DEPTH]; // index 0 newest

    // shift in at the top, oldest falls off the end
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            for (int i = 1; i < DEPTH; i++)
                entry_r[i] <= gsm_pkg::EV_NONE;
            entry_r[0] <= gsm_pkg::EV_PWR_ON;
            count <= IW'(1);
        end
        else if (clkEn && push)
        begin
            entry_r[0] <= pushEvt;
            for (int i = 1; i < DEPTH; i++)
                entry_r[i] <= entry_r[i-1];
            if (count != IW'(DEPTH))
                count <= count + IW'(1);
        end
    end

    // unused slots read as empty
    assign rdEvt = (rdIdx < count) ? entry_r[rdIdx] : gsm_pkg::EV_NONE;

endmodule // gsm_hist_buf

//--- design/gsm_cksum_walk.sv
`timescale 1ns/1ps

module gsm_cksum_walk #(
    parameter int N = 8, // setpoints walked
    parameter int W = 16, // setpoint width
    parameter int IW = 3, // index width
    parameter logic [15:0] MAX = 16'hEA60 // largest valid code
) (
    input wire logic ref_clk, // clock
    input wire logic rst_b, // sync reset, low
    input wire logic clkEn, // freezes state when low
    input wire logic start, // begin one pass
    output logic [IW-1:0] idx, // setpoint being read
    input wire logic [W-1:0] spData, // setpoint at idx
    output logic badHit, // garbled setpoint at idx
    output logic done, // pass finished, one cycle
    output logic [W-1:0] sum // result, valid with done
);

    logic busy; // pass in progress

    // garbled codes count as zero, as they get zeroed
    assign badHit = busy && (spData > W'(MAX));

    // one setpoint per cycle
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            busy <= 1'b0;
            idx <= '0;
            sum <= '0;
            done <= 1'b0;
        end
        else if (clkEn)
        begin
            done <= 1'b0;
            if (start && !busy)
            begin
                busy <= 1'b1;
                idx <= '0;
                sum <= '0;
            end
            else if (busy)
            begin
                sum <= badHit ? sum : sum + spData;
                if (idx == IW'(N - 1))
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                else
                    idx <= idx + IW'(1);
            end
        end
    end

endmodule // gsm_cksum_walk

//--- tb/gsm_tube_model.sv
`timescale 1ns/1ps
// gauge tube with its filament supply
module gsm_tube_model (
    input wire logic ionGaugeOn, // enable
    input wire logic [15:0] pressSet, // chamber
    input wire logic [1:0] faultReq, // fault
    output logic [15:0] pressure, // reading
    output gsm_pkg::gsm_psu_t psuFault // faults
);
    // no ion current when off, so the reading is junk
    assign pressure = ionGaugeOn ? pressSet : ~pressSet;
    // faults only with the filament powered
    assign psuFault = ionGaugeOn ? faultReq : 2'h0;
endmodule // gsm_tube_model

//--- tb/gsm_shutdown_monitor_chk.sv
`timescale 1ns/1ps
// stop causes, relay latch and reset state
module gsm_chk #(
    parameter int HDEPTH = 33 // entries
) (
    input wire logic ref_clk, // clock
    input wire logic rst_b, // reset, low
    input wire logic clkEn, // run
    input wire logic [15:0] pressure, // reading
    input wire logic emisHigh, // range
    input gsm_pkg::gsm_off_t offSrc, // off
    input gsm_pkg::gsm_psu_t psuFault, // faults
    input wire logic ionGaugeOn, // gauge
    input wire logic faultRelay, // relay
    input wire logic irq, // interrupt
    input wire logic [$clog2(HDEPTH+1)-1:0] dispIdx // view
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // gauge running with a stop cause
    sequence stopReq(c);
        ionGaugeOn && clkEn && c;
    endsequence
    // the cause takes the gauge down
    property stops(c);
        stopReq(c) |-> ##[1:2] !ionGaugeOn;
    endproperty
    psu_trip_a: assert property (stops(|psuFault))
        else $error("on in supply fault");
    cmd_off_a: assert property (stops(|offSrc))
        else $error("on after off command");
    ovp_high_a: assert property (stops(pressure > 16'h4E20))
        else $error("on above top limit");
    ovp_low_a: assert property (stops(!emisHigh && pressure > 16'h0320))
        else $error("on above low limit");
    relay_latch_a: assert property (!faultRelay |=> !faultRelay)
        else $error("relay re-energised");
    view_range_a: assert property (dispIdx < HDEPTH)
        else $error("view past end");
    reset_view_a: assert property ($rose(rst_b) |-> dispIdx == 0)
        else $error("view not newest");
    reset_relay_a: assert property ($rose(rst_b) |-> faultRelay && !ionGaugeOn && !irq)
        else $error("bad state after reset");
endmodule // gsm_chk
bind gsm_shutdown_monitor gsm_chk #(.HDEPTH(HDEPTH)) chk (.*);

//--- tb/gauge_shutdown_monitor_tb_top.sv
`timescale 1ns/1ps
`include "gsm_cfg.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin nFail++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
// stimulus, expected values and verdict
module gauge_shutdown_monitor_tb_top;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clkEn = 1'b1; // run, low freezes the block
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] q; // last read
    logic hreadyout;
    logic hresp;
    logic emisHigh = 1'b0;
    logic [15:0] pressSet = 16'h0; // chamber
    logic [15:0] pressure;
    logic [1:0] faultReq = 2'h0;
    gsm_pkg::gsm_psu_t psuFault;
    gsm_pkg::gsm_keys_t keys = 4'h0;
    gsm_pkg::gsm_off_t offSrc = 4'h0;
    logic [2:0] nvmIdx;
    logic [15:0] nvmData;
    logic ionGaugeOn;
    logic faultRelay;
    logic irq;
    logic [5:0] dispIdx;
    gsm_pkg::gsm_evt_t dispEvt;
    // limit rows: low range then high, 100 50 20 10 percent
    logic [15:0] lim [8] = '{16'h0320, 16'h0190, 16'h00A0, 16'h0050,
        16'h4E20, 16'h2710, 16'h0FA0, 16'h07D0};
    int nFail = 0;
    int checks = 0;
    always #25 ref_clk = ~ref_clk;
    // storage holds index times 256
    assign nvmData = {5'h00, nvmIdx, 8'h00};
    gsm_shutdown_monitor #(.CHK_CYCLES(32)) dut (.hready(hreadyout), .*);
    gsm_tube_model tube (.*);
    task give_verdict;
        $display("checks %0d mismatches %0d", checks, nFail);
        if (nFail == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // bounded wait for ready
    task rdy;
        int k;
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 20);
        if (hreadyout !== 1'b1)
        begin
            nFail++;
            give_verdict;
        end
    endtask
    // single word transfer, read data into q
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        rdy;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
        q = hrdata;
    endtask
    // key pulse, up 8 down 4 select 2
    task key(input logic [3:0] k);
        keys <= k;
        tick(1);
        keys <= 4'h0;
        tick(1);
    endtask
    initial
    begin
        tick(12);
        rst_b <= 1'b1;
        tick(40);
        xfer(1, `GSM_REG_MASK, 32'h4);
        // one row per limit
        for (int r = 0; r < 8; r++)
        begin
            emisHigh <= r[2];
            xfer(1, `GSM_REG_CTRL, 32'h4);
            key(4'h2);
            if (r == 4)
                repeat (3) key(4'h8);
            else if (r % 4 != 0)
                key(4'h4);
            key(4'h2);
            xfer(0, `GSM_REG_STATE, 0);
            `CHK(q[3:2], r[1:0])
            xfer(0, `GSM_REG_OVP, 0);
            `CHK(q[15:0], lim[r])
            pressSet <= lim[r];
            xfer(1, `GSM_REG_CTRL, 32'h5);
            tick(3);
            `CHK(ionGaugeOn, 1'b1)
            pressSet <= lim[r] + 16'h1;
            tick(3);
            `CHK({ionGaugeOn, irq}, 2'b01)
            xfer(0, `GSM_REG_STAT, 0);
            tick(2);
            `CHK({irq, q[4:0]}, 6'h04)
        end
        pressSet <= 16'h0001;
        // commanded and supply stops, masked
        for (int i = 0; i < 36; i++)
        begin
            xfer(1, `GSM_REG_CTRL, 32'h9);
            tick(2);
            if (i < 4)
                offSrc <= 4'h8 >> i;
            else
                faultReq <= i[0] ? 2'h2 : 2'h1;
            tick(1);
            offSrc <= 4'h0;
            faultReq <= 2'h0;
            tick(3);
            `CHK({ionGaugeOn, irq, dispEvt}, {2'b00, i < 4 ? 3'h2 : 3'h3})
        end
        xfer(0, `GSM_REG_STATE, 0);
        `CHK(q[13:8], 6'h21)
        repeat (40) key(4'h4);
        tick(3);
        `CHK({dispIdx, dispEvt}, {6'h20, gsm_pkg::EV_COMMANDED_OFF})
        key(4'h8);
        tick(3);
        `CHK({dispIdx, dispEvt}, {6'h1F, gsm_pkg::EV_SUPPLY_OFF})
        // a key press while frozen is lost
        clkEn <= 1'b0;
        key(4'h8);
        clkEn <= 1'b1;
        tick(3);
        `CHK(dispIdx, 6'h1F)
        xfer(1, `GSM_REG_SPIDX, 32'h1);
        xfer(0, `GSM_REG_SPDAT, 0);
        `CHK(q[15:0], 16'h0100)
        xfer(1, `GSM_REG_SPDAT, 32'h1234);
        tick(100);
        `CHK(faultRelay, 1'b1)
        xfer(1, `GSM_REG_SPDAT, 32'hFFFF);
        tick(100);
        xfer(0, `GSM_REG_SPDAT, 0);
        `CHK({faultRelay, q[15:0]}, 17'h0)
        xfer(0, `GSM_REG_STAT, 0);
        `CHK(q[4], 1'b1)
        rst_b <= 1'b0;
        tick(12);
        rst_b <= 1'b1;
        tick(40);
        xfer(0, `GSM_REG_STATE, 0);
        `CHK({hresp, nvmIdx, q[21:0]}, {1'b0, 3'h7, 22'h000102})
        `CHK(dispEvt, gsm_pkg::EV_PWR_ON)
        give_verdict;
    end
endmodule // gauge_shutdown_monitor_tb_top
